//--- hdl/qa_wd_pkg.sv
package qa_wd_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WINDOW = 8'h04;
    localparam logic [7:0] ADDR_QA_CFG = 8'h08;
    localparam logic [7:0] ADDR_QUESTION = 8'h0c;
    localparam logic [7:0] ADDR_ANSWER = 8'h10;
    localparam logic [7:0] ADDR_LIMIT = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int QA_OPT_LSB = 0;
    localparam int QA_POLY_LSB = 2;
    localparam int QA_SEED_LSB = 4;
    localparam int QUESTION_LSB = 0;
    localparam int QUESTION_ERR_BIT = 6;
    localparam int STATUS_FAIL_LSB = 0;
    localparam int STATUS_ANSW_LSB = 4;
    localparam int STATUS_PHASE_LSB = 8;

    // Reset values
    localparam logic CTRL_EN_RST = 1'h0;
    localparam logic [15:0] WINDOW_MS_RST = 16'h0400;
    localparam logic [1:0] QA_OPT_RST = 2'h0;
    localparam logic [1:0] QA_POLY_RST = 2'h0;
    localparam logic [3:0] QA_SEED_RST = 4'ha;
    localparam logic [3:0] LIMIT_RST = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RW1 = 3'b010,
        ST_RW2 = 3'b100
    } phase_t;

    // Question update, a small LFSR step chosen by the polynomial select
    function automatic logic [3:0] next_question(input logic [3:0] q, input logic [1:0] sel);
        logic fb;
        fb = 1'b0;
        case (sel)
            2'h0: fb = q[3] ^ q[2];
            2'h1: fb = q[3] ^ q[0];
            2'h2: fb = q[3] ^ q[1];
            default: fb = ~(q[3] ^ q[2]);
        endcase
        return {q[2:0], fb};
    endfunction

    // Expected answer byte for a question and an answer position
    function automatic logic [7:0] expected_answer(input logic [3:0] q, input logic [1:0] pos,
                                                   input logic [1:0] opt);
        logic [3:0] lo;
        lo = q ^ {pos, opt};
        return {~lo ^ {2'h0, pos}, lo};
    endfunction

endpackage

//--- hdl/ms_tick_divider.sv
`timescale 1ns/10ps
`default_nettype none

module ms_tick_divider #(
    parameter int CYCLES = 10000
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic run_in,
    output logic tick_out
);

    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (clear_in || !run_in) begin
            next_count = 16'h0000;
        end else if (count == 16'(CYCLES - 1)) begin
            next_count = 16'h0000;
            next_tick = 1'b1;
        end else begin
            next_count = 16'(count + 16'h0001);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            count <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            count <= next_count;
            tick_out <= next_tick;
        end
    end

endmodule

`default_nettype wire

//--- hdl/qa_fail_counter.sv
`timescale 1ns/10ps
`default_nettype none

module qa_fail_counter (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic inc_in,
    input wire logic dec_in,
    input wire logic [3:0] limit_in,
    output logic [3:0] count_out,
    output logic action_out
);

    logic [3:0] next_count;
    logic next_action;

    // Saturating counter; action fires on the failure that reaches the limit
    always_comb begin
        next_count = count_out;
        next_action = 1'b0;
        if (inc_in) begin
            if (count_out != 4'hf) begin
                next_count = 4'(count_out + 4'h1);
            end
            next_action = (limit_in != 4'h0) && (4'(count_out + 4'h1) == limit_in);
        end else if (dec_in && count_out != 4'h0) begin
            next_count = 4'(count_out - 4'h1);
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            count_out <= 4'h0;
            action_out <= 1'b0;
        end else begin
            count_out <= next_count;
            action_out <= next_action;
        end
    end

endmodule

`default_nettype wire

//--- hdl/qa_watchdog_evaluator.sv
`timescale 1ns/10ps
`default_nettype none

module qa_watchdog_evaluator
    import qa_wd_pkg::*;
#(
    parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic wd_action_out,
    output logic qa_error_flag_out
);

    // APB slave state
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic acc;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_word;

    // Configuration
    logic enable;
    logic [15:0] window_ms;
    logic [1:0] ans_opt;
    logic [1:0] poly_sel;
    logic [3:0] seed;
    logic [3:0] limit;
    logic next_enable;
    logic [15:0] next_window_ms;
    logic [1:0] next_ans_opt;
    logic [1:0] next_poly_sel;
    logic [3:0] next_seed;
    logic [3:0] next_limit;

    // Sequencer
    phase_t phase;
    phase_t next_phase;
    logic [2:0] w1_cnt;
    logic [2:0] w1_ok;
    logic [2:0] w2_cnt;
    logic [2:0] next_w1_cnt;
    logic [2:0] next_w1_ok;
    logic [2:0] next_w2_cnt;
    logic [3:0] question;
    logic [3:0] next_question_q;
    logic qa_error_flag;
    logic next_qa_error_flag;
    logic [15:0] ms_cnt;
    logic [15:0] next_ms_cnt;

    logic ans_wr;
    logic [2:0] total;
    logic [1:0] pos;
    logic correct;
    logic pass_evt;
    logic fail_evt;
    logic restart;
    logic ms_tick;
    logic [3:0] fail_count;

    assign acc = psel_in && penable_in && pready_out;
    assign wr_acc = acc && pwrite_in;
    assign total = 3'(w1_cnt + w2_cnt);
    assign pos = 2'(3'h3 - total);
    assign ans_wr = wr_acc && (paddr_in == ADDR_ANSWER) && (phase != ST_IDLE);
    assign correct = (pwdata_in[7:0] == expected_answer(question, pos, ans_opt));

    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr_in)
            ADDR_CTRL: rd_word[CTRL_EN_BIT] = enable;
            ADDR_WINDOW: rd_word[15:0] = window_ms;
            ADDR_QA_CFG: begin
                rd_word[QA_OPT_LSB +: 2] = ans_opt;
                rd_word[QA_POLY_LSB +: 2] = poly_sel;
                rd_word[QA_SEED_LSB +: 4] = seed;
            end
            ADDR_QUESTION: begin
                rd_word[QUESTION_LSB +: 4] = question;
                rd_word[QUESTION_ERR_BIT] = qa_error_flag;
            end
            ADDR_ANSWER: rd_word = 32'h0000_0000;
            ADDR_LIMIT: rd_word[3:0] = limit;
            ADDR_STATUS: begin
                rd_word[STATUS_FAIL_LSB +: 4] = fail_count;
                rd_word[STATUS_ANSW_LSB +: 2] = total[1:0];
                rd_word[STATUS_PHASE_LSB +: 3] = phase;
            end
            default: mapped = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_comb begin
        next_pready = psel_in && penable_in && !pready_out;
        next_prdata = prdata_out;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_prdata = pwrite_in ? 32'h0000_0000 : rd_word;
            next_pslverr = !mapped;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= next_pready;
            prdata_out <= next_prdata;
            pslverr_out <= next_pslverr;
        end
    end

    always_comb begin
        next_enable = enable;
        next_window_ms = window_ms;
        next_ans_opt = ans_opt;
        next_poly_sel = poly_sel;
        next_seed = seed;
        next_limit = limit;
        if (wr_acc) begin
            case (paddr_in)
                ADDR_CTRL: next_enable = pwdata_in[CTRL_EN_BIT];
                ADDR_WINDOW: next_window_ms = pwdata_in[15:0];
                ADDR_QA_CFG: begin
                    next_ans_opt = pwdata_in[QA_OPT_LSB +: 2];
                    next_poly_sel = pwdata_in[QA_POLY_LSB +: 2];
                    next_seed = pwdata_in[QA_SEED_LSB +: 4];
                end
                ADDR_LIMIT: next_limit = pwdata_in[3:0];
                default: next_enable = enable;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            enable <= CTRL_EN_RST;
            window_ms <= WINDOW_MS_RST;
            ans_opt <= QA_OPT_RST;
            poly_sel <= QA_POLY_RST;
            seed <= QA_SEED_RST;
            limit <= LIMIT_RST;
        end else begin
            enable <= next_enable;
            window_ms <= next_window_ms;
            ans_opt <= next_ans_opt;
            poly_sel <= next_poly_sel;
            seed <= next_seed;
            limit <= next_limit;
        end
    end

    // Cycle outcome evaluation
    always_comb begin
        next_phase = phase;
        next_w1_cnt = w1_cnt;
        next_w1_ok = w1_ok;
        next_w2_cnt = w2_cnt;
        next_question_q = question;
        next_qa_error_flag = qa_error_flag;
        next_ms_cnt = ms_tick ? 16'(ms_cnt + 16'h0001) : ms_cnt;
        pass_evt = 1'b0;
        fail_evt = 1'b0;
        restart = 1'b0;
        case (phase)
            ST_IDLE: begin
                next_ms_cnt = 16'h0000;
                if (enable) begin
                    next_question_q = seed;
                    next_phase = ST_RW1;
                    restart = 1'b1;
                end
            end
            ST_RW1: begin
                if (ans_wr) begin
                    if (w1_cnt == 3'h3) begin
                        fail_evt = 1'b1;
                    end else begin
                        next_w1_cnt = 3'(w1_cnt + 3'h1);
                        next_w1_ok = correct ? 3'(w1_ok + 3'h1) : w1_ok;
                    end
                end else if (ms_cnt >= (window_ms >> 1)) begin
                    next_phase = ST_RW2;
                end
            end
            ST_RW2: begin
                if (ans_wr) begin
                    if (total == 3'h3) begin
                        if (w1_cnt == 3'h3 && w1_ok == 3'h3 && correct) begin
                            pass_evt = 1'b1;
                        end else begin
                            fail_evt = 1'b1;
                        end
                    end else begin
                        next_w2_cnt = 3'(w2_cnt + 3'h1);
                    end
                end else if (ms_cnt >= window_ms) begin
                    fail_evt = 1'b1;
                end
            end
            default: next_phase = ST_IDLE;
        endcase
        if (pass_evt) begin
            next_question_q = next_question(question, poly_sel);
            next_qa_error_flag = 1'b0;
            restart = 1'b1;
        end
        if (fail_evt) begin
            next_qa_error_flag = 1'b1;
            restart = 1'b1;
        end
        if (restart) begin
            next_phase = ST_RW1;
            next_w1_cnt = 3'h0;
            next_w1_ok = 3'h0;
            next_w2_cnt = 3'h0;
            next_ms_cnt = 16'h0000;
        end
        if (!enable) begin
            next_phase = ST_IDLE;
            next_w1_cnt = 3'h0;
            next_w1_ok = 3'h0;
            next_w2_cnt = 3'h0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            phase <= ST_IDLE;
            w1_cnt <= 3'h0;
            w1_ok <= 3'h0;
            w2_cnt <= 3'h0;
            question <= QA_SEED_RST;
            qa_error_flag <= 1'b0;
            qa_error_flag_out <= 1'b0;
            ms_cnt <= 16'h0000;
        end else begin
            phase <= next_phase;
            w1_cnt <= next_w1_cnt;
            w1_ok <= next_w1_ok;
            w2_cnt <= next_w2_cnt;
            question <= next_question_q;
            qa_error_flag <= next_qa_error_flag;
            qa_error_flag_out <= next_qa_error_flag;
            ms_cnt <= next_ms_cnt;
        end
    end

    ms_tick_divider #(
        .CYCLES(CYCLES_PER_MS_P)
    ) u_tick (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .clear_in(restart),
        .run_in(phase != ST_IDLE),
        .tick_out(ms_tick)
    );

    qa_fail_counter u_fail (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .inc_in(fail_evt),
        .dec_in(pass_evt),
        .limit_in(limit),
        .count_out(fail_count),
        .action_out(wd_action_out)
    );

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_pass_restart;
        pass_evt |=> phase == ST_RW1 && !qa_error_flag_out
            && question == next_question($past(question), poly_sel)
            && fail_count == ($past(fail_count) == 4'h0 ? 4'h0 : 4'($past(fail_count) - 4'h1));
    endproperty
    a_pass_restart: assert property (p_pass_restart) else $error("pass outcome wrong");

    property p_fail_same_question;
        fail_evt |=> qa_error_flag_out && question == $past(question)
            && (fail_count == 4'hf || fail_count == 4'($past(fail_count) + 4'h1));
    endproperty
    a_fail_same_question: assert property (p_fail_same_question) else $error("fail outcome wrong");

    property p_timeout_only_at_end;
        fail_evt && !ans_wr |-> phase == ST_RW2 && ms_cnt >= window_ms && total < 3'h4;
    endproperty
    a_timeout_only_at_end: assert property (p_timeout_only_at_end) else $error("early timeout");

    property p_fourth_restarts;
        ans_wr && phase == ST_RW2 && total == 3'h3 |=> phase == ST_RW1 && ms_cnt == 16'h0000
            && w2_cnt == 3'h0;
    endproperty
    a_fourth_restarts: assert property (p_fourth_restarts) else $error("no restart on 4th");

    property p_four_in_first;
        ans_wr && phase == ST_RW1 && w1_cnt == 3'h3 |-> fail_evt ##1 w1_cnt == 3'h0;
    endproperty
    a_four_in_first: assert property (p_four_in_first) else $error("4 in window 1 passed");

    property p_silent_second;
        phase == ST_RW2 && w2_cnt == 3'h0 && ms_cnt >= window_ms && !ans_wr
            |-> !pass_evt ##1 qa_error_flag_out;
    endproperty
    a_silent_second: assert property (p_silent_second) else $error("silent window passed");

    property p_err_readback;
        pready_out && !pwrite_in && paddr_in == ADDR_QUESTION
            |-> prdata_out[QUESTION_ERR_BIT] == $past(qa_error_flag);
    endproperty
    a_err_readback: assert property (p_err_readback) else $error("error bit readback");

    property p_limit_action;
        fail_evt && limit != 4'h0 && fail_count == 4'(limit - 4'h1) |=> wd_action_out;
    endproperty
    a_limit_action: assert property (p_limit_action) else $error("missing action");

    property p_reset_defaults;
        $past(rst_n_in) == 1'b0 |-> seed == 4'ha && ans_opt == 2'h0 && poly_sel == 2'h0;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset defaults");

    property p_window_split;
        phase == ST_RW1 ##1 phase == ST_RW2 |-> $past(ms_cnt) >= (window_ms >> 1);
    endproperty
    a_window_split: assert property (p_window_split) else $error("window 2 too early");

    property p_answer_count;
        ans_wr && phase == ST_RW1 && w1_cnt < 3'h3 |=> w1_cnt == 3'($past(w1_cnt) + 3'h1);
    endproperty
    a_answer_count: assert property (p_answer_count) else $error("answer not counted");

    c_pass: cover property (pass_evt);
    c_timeout_fail: cover property (fail_evt && !ans_wr);
    c_action: cover property (wd_action_out);
    c_unmapped: cover property (pready_out && pslverr_out);

endmodule

`default_nettype wire

//--- verif/host_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_mcu_model
    import qa_wd_pkg::*;
(
    input wire logic clock_in,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out
);
    logic [31:0] rdata;
    logic err;

    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge clock_in);
        psel_out <= 1'b1;
        pwrite_out <= wr;
        paddr_out <= addr;
        pwdata_out <= wdata;
        @(posedge clock_in);
        penable_out <= 1'b1;
        @(posedge clock_in);
        while (pready_in !== 1'b1) @(posedge clock_in);
        rdata = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Released data does not keep its last value
        pwdata_out <= ~wdata;
    endtask

    function automatic logic [7:0] answer(input logic [3:0] q, input logic [1:0] pos,
                                          input logic [1:0] opt);
        logic [3:0] l;
        l = q ^ {pos, opt};
        return {~l ^ {2'h0, pos}, l};
    endfunction

    // Read question, n1 answers in window one, n2 in window two; bad flips bit 0
    task automatic qa_cycle(input int n1, input int n2, input logic [3:0] bad,
                            input logic [1:0] opt);
        logic [3:0] q;
        int pos;
        xfer(1'b0, ADDR_QUESTION, 32'h0);
        q = rdata[3:0];
        pos = 3;
        for (int i = 0; i < n1; i++) begin
            xfer(1'b1, ADDR_ANSWER, {24'h0, answer(q, 2'(pos), opt) ^ {7'h0, bad[pos]}});
            pos--;
        end
        if (n1 < 4) begin
            do xfer(1'b0, ADDR_STATUS, 32'h0); while (rdata[10:8] !== 3'b100);
        end
        for (int i = 0; i < n2; i++) begin
            xfer(1'b1, ADDR_ANSWER, {24'h0, answer(q, 2'(pos), opt) ^ {7'h0, bad[pos]}});
            pos--;
        end
    endtask
endmodule

`default_nettype wire

//--- verif/tb_question_answer_watchdog_evaluator.sv
`timescale 1ns/10ps
`default_nettype none

module tb_question_answer_watchdog_evaluator
    import qa_wd_pkg::*;
;
    localparam logic [3:0] LIM = 4'h3;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, wd_action, qa_flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] opt;
    logic [1:0] poly;
    logic [3:0] exp_q, exp_fail;
    logic exp_flag;
    int n_errors = 0;
    int compares = 0;
    int exp_act = 0;
    int n_act = 0;

    qa_watchdog_evaluator #(.CYCLES_PER_MS_P(4)) dut_u (
        .clock_in(clock), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .wd_action_out(wd_action),
        .qa_error_flag_out(qa_flag)
    );

    host_mcu_model host_u (
        .clock_in(clock), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata)
    );

    initial begin
        forever #50 clock = ~clock;
    end

    always @(posedge clock) begin
        if (wd_action === 1'b1) n_act++;
    end

    task automatic end_sim;
        $display("comparisons %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        host_u.xfer(1'b0, a, 32'h0);
    endtask

    // Question step for each polynomial select
    function automatic logic [3:0] lfsr(input logic [3:0] q, input logic [1:0] sel);
        logic fb;
        case (sel)
            2'h0: fb = q[3] ^ q[2];
            2'h1: fb = q[3] ^ q[0];
            2'h2: fb = q[3] ^ q[1];
            default: fb = ~(q[3] ^ q[2]);
        endcase
        return {q[2:0], fb};
    endfunction

    task automatic run(input int n1, input int n2, input logic [3:0] bad);
        logic pass;
        pass = (n1 == 3) && (n2 == 1) && (bad == 4'h0);
        host_u.qa_cycle(n1, n2, bad, opt);
        if (n1 + n2 < 4) begin
            rd(ADDR_STATUS);
            check("still_w2", host_u.rdata[10:8], 3'b100);
            check("ans_cnt", host_u.rdata[5:0], {2'(n1 + n2), exp_fail});
            do rd(ADDR_STATUS); while (host_u.rdata[10:8] !== 3'b010);
        end
        if (pass) begin
            if (exp_fail != 4'h0) exp_fail--;
            exp_q = lfsr(exp_q, poly);
            exp_flag = 1'b0;
        end else begin
            if (exp_fail != 4'hf) exp_fail++;
            if (exp_fail == LIM) exp_act++;
            exp_flag = 1'b1;
        end
        rd(ADDR_STATUS);
        check("status", {host_u.rdata[10:8], host_u.rdata[5:0]}, {3'b010, 2'h0, exp_fail});
        rd(ADDR_QUESTION);
        check("question", {host_u.rdata[6], host_u.rdata[3:0]}, {exp_flag, exp_q});
        check("flag_pin", qa_flag, exp_flag);
    endtask

    initial begin
        logic [3:0] seed;
        int n1;
        int n2;
        void'($urandom(50));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(ADDR_QA_CFG);
        check("cfg_rst", host_u.rdata[7:0], 8'ha0);
        rd(ADDR_QUESTION);
        check("question_rst", host_u.rdata[6:0], 7'h0a);
        rd(ADDR_WINDOW);
        check("window_rst", host_u.rdata[15:0], 16'h0400);
        rd(8'h1c);
        check("unmapped_err", host_u.err, 1'b1);
        opt = 2'($urandom_range(3, 0));
        poly = 2'($urandom_range(3, 0));
        seed = 4'($urandom_range(15, 0));
        host_u.xfer(1'b1, ADDR_QA_CFG, {24'h0, seed, poly, opt});
        host_u.xfer(1'b1, ADDR_WINDOW, 32'h18);
        rd(ADDR_WINDOW);
        check("window", host_u.rdata[15:0], 16'h0018);
        check("mapped_ok", host_u.err, 1'b0);
        host_u.xfer(1'b1, ADDR_LIMIT, {28'h0, LIM});
        rd(ADDR_LIMIT);
        check("limit", host_u.rdata[3:0], LIM);
        host_u.xfer(1'b1, ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL);
        check("enable", host_u.rdata[0], 1'b1);
        exp_q = seed;
        exp_fail = 4'h0;
        exp_flag = 1'b0;
        run(3, 1, 4'h0);
        run(4, 0, 4'h0);
        run(3, 0, 4'h0);
        run(3, 1, 4'h1);
        run(0, 4, 4'h0);
        run(2, 1, 4'h0);
        run(0, 0, 4'h0);
        run(3, 1, 4'h0);
        for (int i = 0; i < 16; i++) begin
            // Walk every polynomial select and a fresh answer option per cycle
            poly = 2'(i);
            opt = 2'($urandom_range(3, 0));
            host_u.xfer(1'b1, ADDR_QA_CFG, {24'h0, seed, poly, opt});
            n1 = $urandom_range(4, 0);
            n2 = (n1 == 4) ? 0 : $urandom_range(4 - n1, 0);
            if ($urandom_range(1, 0) == 1) begin
                n1 = 3;
                n2 = 1;
            end
            run(n1, n2, ($urandom_range(2, 0) == 0) ? 4'($urandom_range(15, 0)) : 4'h0);
        end
        // Abort by clearing enable; an answer while idle is ignored
        host_u.xfer(1'b1, ADDR_CTRL, 32'h0);
        host_u.xfer(1'b1, ADDR_ANSWER, 32'h0);
        rd(ADDR_STATUS);
        check("idle_status", {host_u.rdata[10:8], host_u.rdata[5:0]}, {3'b001, 2'h0, exp_fail});
        rd(ADDR_QUESTION);
        check("idle_question", {host_u.rdata[6], host_u.rdata[3:0]}, {exp_flag, exp_q});
        repeat (2) @(posedge clock);
        check("action_pulses", n_act, exp_act);
        end_sim();
    end

    initial begin
        repeat (50000) @(posedge clock);
        n_errors++;
        end_sim();
    end
endmodule

`default_nettype wire
